// ### pkg/uotg_pkg.sv
package uotg_pkg;

  // Register byte offsets
  localparam logic [11:0] UOTG_CTRL_OFS = 12'h800;
  localparam logic [11:0] UOTG_STATUS_OFS = 12'h804;
  localparam logic [11:0] UOTG_CLEAR_OFS = 12'h808;
  localparam logic [11:0] UOTG_SET_OFS = 12'h80c;
  localparam logic [11:0] UOTG_VERSION_OFS = 12'h818;
  localparam logic [11:0] UOTG_FEATURES_OFS = 12'h81c;

  // Flag positions in status, clear and set words
  localparam int UOTG_IDPIN_BIT = 0;
  localparam int UOTG_SUPPLY_EDGE_BIT = 1;
  localparam int UOTG_SESSION_BIT = 2;
  localparam int UOTG_SUPPLY_ERR_BIT = 3;
  localparam int UOTG_BCONN_BIT = 4;
  localparam int UOTG_ROLE_BIT = 5;
  localparam int UOTG_NEG_ERR_BIT = 6;
  localparam int UOTG_SUSP_TO_BIT = 7;
  localparam int UOTG_SUPPLY_REQ_BIT = 9;
  localparam int UOTG_ID_LEVEL_BIT = 10;
  localparam int UOTG_SUPPLY_LEVEL_BIT = 11;
  localparam int UOTG_NFLAGS = 8;

  // Control word: enables in 7:0, hardware supply control disable at 8
  localparam int UOTG_HWC_DIS_BIT = 8;
  localparam int UOTG_FREEZE_BIT = 14;

  // Version word layout
  localparam int UOTG_VERSION_LSB = 0;
  localparam int UOTG_VARIANT_LSB = 16;

  // Features word layout
  localparam int UOTG_EPCNT_LSB = 0;
  localparam int UOTG_DMACH_LSB = 4;
  localparam int UOTG_DMALEN_BIT = 7;
  localparam int UOTG_DMAFIFO_LSB = 8;
  localparam int UOTG_FIFOSZ_LSB = 12;
  localparam int UOTG_BYTEWR_BIT = 15;
  localparam int UOTG_PATH_BIT = 16;
  localparam int UOTG_HBISO_LSB = 17;

  localparam logic [31:0] UOTG_CTRL_RESET = 32'h0000_0000;
  localparam logic [UOTG_NFLAGS-1:0] UOTG_FLAGS_RESET = 8'h00;

  // Pin slots in the synchroniser vector; id idles high on its pull-up
  localparam int UOTG_ID_PIN = 0;
  localparam int UOTG_SUPPLY_PIN = 1;
  localparam int UOTG_NPINS = 2;
  localparam logic [UOTG_NPINS-1:0] UOTG_PINS_IDLE = 2'h1;
  // Cycles after reset before a pin change counts as an edge
  localparam int UOTG_ARM_CYCLES = 3;

  // Hardware event strobes
  typedef struct packed {
    logic susp_timeout;
    logic neg_error;
    logic role_swap;
    logic bconn_error;
    logic supply_error;
    logic session_request;
  } uotg_events_type;

endpackage

// ### design/uotg_status_flags.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - Role swap after negotiation sets its flag
// - Error during B-connection sets its flag
// - Supply drop sets supply error flag
// - Supply error flags even with hardware control off
// - Detected session request sets its flag
// - Either edge on supply pad sets flag
// - Either edge on id pin sets flag
// - Pin edges detected regardless of clock freeze
// - Clear register ones clear matching flags
// - Set register ones force matching flags
// - Zero writes ignored; clear/set read zero
// - Supply request bit 9, flags 7..0
// - Version register gives version and variant
// - Features bits 23..17 high-bandwidth iso per endpoint
// - Bit 16 reports macrocell path width
// - Bit 15 reports native byte write RAM
// - Three-bit FIFO RAM size code
// - Four-bit DMA FIFO depth code
// - Bit 7 reports DMA length counter width
// - Four-bit endpoint count code
module uotg_status_flags
  import uotg_pkg::*;
#(
  parameter logic [11:0] VERSION_NUM = 12'h001,
  parameter logic [3:0] VARIANT_NUM = 4'h0,
  parameter logic [6:0] HB_ISO_EP = 7'h00,
  parameter bit MACROCELL_16BIT = 1'b0,
  parameter bit NATIVE_BYTE_WRITE = 1'b0,
  parameter int FIFO_RAM_CODE = 7,
  parameter int DMA_FIFO_CODE = 0,
  parameter int DMA_CHANNELS = 7,
  parameter bit DMA_LEN_24BIT = 1'b1,
  parameter int ENDPOINT_CODE = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire uotg_events_type events,
  input wire logic supply_pad,
  input wire logic id_pin,
  output logic usb_irq,
  output logic supply_request,
  output logic clock_freeze,
  output logic supply_hw_ctrl_disable
);

  //////////////////////////////////////////////////////////////////////////////
  // Parameter checks, refused at elaboration

  if (FIFO_RAM_CODE < 0 || FIFO_RAM_CODE > 7) begin : g_bad_fifo_code
    $error("fifo code out of range");
  end
  if (DMA_FIFO_CODE < 0 || DMA_FIFO_CODE > 15) begin : g_bad_dma_fifo_code
    $error("dma fifo code out of range");
  end
  if (DMA_CHANNELS < 1 || DMA_CHANNELS > 7) begin : g_bad_dma_channels
    $error("dma channels out of range");
  end
  if (ENDPOINT_CODE < 0 || ENDPOINT_CODE > 15) begin : g_bad_endpoint_code
    $error("endpoint code out of range");
  end
  // Arming shift needs at least two stages
  if (UOTG_ARM_CYCLES < 2) begin : g_bad_arm_cycles
    $error("arm cycles too small");
  end
  // Flag word must stay below the request bit
  if (UOTG_NFLAGS > UOTG_SUPPLY_REQ_BIT) begin : g_bad_flag_count
    $error("flag count overlaps request bit");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [UOTG_NPINS-1:0] pin_raw;
  wire logic [UOTG_NPINS-1:0] pin_level;
  wire logic [UOTG_NPINS-1:0] pin_edge;
  logic [UOTG_ARM_CYCLES-1:0] arm_q;
  logic armed;
  logic supply_edge;
  logic id_edge;
  logic supply_level;
  logic id_level;

  always_comb begin
    pin_raw = '0;
    pin_raw[UOTG_ID_PIN] = id_pin;
    pin_raw[UOTG_SUPPLY_PIN] = supply_pad;
  end

  // Edges count only once the chain holds real pin samples;
  // a change in the first few cycles after reset is not flagged
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      arm_q <= '0;
    end else begin
      arm_q <= {arm_q[UOTG_ARM_CYCLES-2:0], 1'b1};
    end
  end
  assign armed = arm_q[UOTG_ARM_CYCLES-1];

  // Runs on the free bus clock, so freezing the core clock has no effect
  for (genvar p = 0; p < UOTG_NPINS; p++) begin : g_pin
    logic meta_q;
    logic sync_q;
    logic prev_q;
    // Reset to the idle level so status reads right straight after reset
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        meta_q <= UOTG_PINS_IDLE[p];
        sync_q <= UOTG_PINS_IDLE[p];
        prev_q <= UOTG_PINS_IDLE[p];
      end else begin
        meta_q <= pin_raw[p];
        sync_q <= meta_q;
        prev_q <= sync_q;
      end
    end
    assign pin_level[p] = sync_q;
    assign pin_edge[p] = armed && (prev_q != sync_q);
  end

  assign supply_edge = pin_edge[UOTG_SUPPLY_PIN];
  assign id_edge = pin_edge[UOTG_ID_PIN];
  assign supply_level = pin_level[UOTG_SUPPLY_PIN];
  assign id_level = pin_level[UOTG_ID_PIN];

  //////////////////////////////////////////////////////////////////////////////
  // Register strobes

  logic wr_ctrl;
  logic wr_clear;
  logic wr_set;
  assign wr_ctrl = wr_en && (addr == UOTG_CTRL_OFS);
  assign wr_clear = wr_en && (addr == UOTG_CLEAR_OFS);
  assign wr_set = wr_en && (addr == UOTG_SET_OFS);

  logic [31:0] ctrl_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= UOTG_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky flags

  logic [UOTG_NFLAGS-1:0] hw_set;
  logic [UOTG_NFLAGS-1:0] flags_q;
  logic [UOTG_NFLAGS-1:0] flags_d;
  logic [UOTG_NFLAGS-1:0] sw_clr;
  logic [UOTG_NFLAGS-1:0] sw_set;

  always_comb begin
    hw_set = '0;
    hw_set[UOTG_IDPIN_BIT] = id_edge;
    hw_set[UOTG_SUPPLY_EDGE_BIT] = supply_edge;
    hw_set[UOTG_SESSION_BIT] = events.session_request;
    // Raised whatever the hardware control setting
    hw_set[UOTG_SUPPLY_ERR_BIT] = events.supply_error;
    hw_set[UOTG_BCONN_BIT] = events.bconn_error;
    hw_set[UOTG_ROLE_BIT] = events.role_swap;
    hw_set[UOTG_NEG_ERR_BIT] = events.neg_error;
    hw_set[UOTG_SUSP_TO_BIT] = events.susp_timeout;
  end

  assign sw_clr = wr_clear ? wdata[UOTG_NFLAGS-1:0] : '0;
  assign sw_set = wr_set ? wdata[UOTG_NFLAGS-1:0] : '0;
  // Set wins over a clear in the same cycle so no event is lost
  assign flags_d = (flags_q & ~sw_clr) | sw_set | hw_set;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= UOTG_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Supply request: software set, cleared by software or by a supply fault while hardware control is on (bit 8 clear)
  logic req_d;
  always_comb begin
    req_d = supply_request;
    if ((wr_clear && wdata[UOTG_SUPPLY_REQ_BIT]) ||
        (events.supply_error && !ctrl_q[UOTG_HWC_DIS_BIT])) begin
      req_d = 1'b0;
    end
    if (wr_set && wdata[UOTG_SUPPLY_REQ_BIT]) begin
      req_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      supply_request <= 1'b0;
    end else begin
      supply_request <= req_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt and control outputs

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      usb_irq <= 1'b0;
    end else begin
      // From next flags so the line tracks the flags without extra lag
      usb_irq <= |(flags_d & ctrl_q[UOTG_NFLAGS-1:0]);
    end
  end

  // Control outputs trail their register bit by one cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clock_freeze <= 1'b0;
    end else begin
      clock_freeze <= ctrl_q[UOTG_FREEZE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      supply_hw_ctrl_disable <= 1'b0;
    end else begin
      supply_hw_ctrl_disable <= ctrl_q[UOTG_HWC_DIS_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Constant words

  logic [31:0] version_word;
  logic [31:0] features_word;

  always_comb begin
    version_word = '0;
    version_word[UOTG_VERSION_LSB +: 12] = VERSION_NUM;
    version_word[UOTG_VARIANT_LSB +: 4] = VARIANT_NUM;
  end

  always_comb begin
    features_word = '0;
    features_word[UOTG_EPCNT_LSB +: 4] = ENDPOINT_CODE[3:0];
    features_word[UOTG_DMACH_LSB +: 3] = DMA_CHANNELS[2:0];
    features_word[UOTG_DMALEN_BIT] = DMA_LEN_24BIT;
    features_word[UOTG_DMAFIFO_LSB +: 4] = DMA_FIFO_CODE[3:0];
    features_word[UOTG_FIFOSZ_LSB +: 3] = FIFO_RAM_CODE[2:0];
    features_word[UOTG_BYTEWR_BIT] = NATIVE_BYTE_WRITE;
    features_word[UOTG_PATH_BIT] = MACROCELL_16BIT;
    features_word[UOTG_HBISO_LSB +: 7] = HB_ISO_EP;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path, data one cycle after the strobe

  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[UOTG_NFLAGS-1:0] = flags_q;
    status_word[UOTG_SUPPLY_REQ_BIT] = supply_request;
    status_word[UOTG_ID_LEVEL_BIT] = id_level;
    status_word[UOTG_SUPPLY_LEVEL_BIT] = supply_level;
  end

  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = '0;
    unique case (addr)
      UOTG_CTRL_OFS: rdata_d = ctrl_q;
      UOTG_STATUS_OFS: rdata_d = status_word;
      UOTG_VERSION_OFS: rdata_d = version_word;
      UOTG_FEATURES_OFS: rdata_d = features_word;
      // Clear, set and unmapped addresses read zero
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd_en) begin
      rdata <= rdata_d;
    end else begin
      rdata <= '0;
    end
  end

endmodule // uotg_status_flags

// ### tb/uotg_props.sv
`timescale 1ns/10ps
module uotg_props
  import uotg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire uotg_events_type events,
  input wire logic supply_pad,
  input wire logic id_pin,
  input wire logic usb_irq,
  input wire logic supply_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] en_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Enables mirrored here, the ports alone do not show the mask
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      en_q <= 8'h00;
    end else if (wr_en && addr == UOTG_CTRL_OFS) begin
      en_q <= wdata[7:0];
    end
  end
  sequence s_wr(logic [11:0] a, int b);
    wr_en && addr == a && wdata[b];
  endsequence
  sequence s_edge(logic lvl, int b);
    $changed(lvl) && en_q[b];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  property p_rd_idle; !rd_en |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
  property p_clr_rd;
    rd_en && (addr == UOTG_CLEAR_OFS || addr == UOTG_SET_OFS) |=> rdata == 32'h0;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear or set read not zero");
  property p_vers;
    rd_en && addr == UOTG_VERSION_OFS |=> rdata[31:20] == 12'h0 && rdata[15:12] == 4'h0;
  endproperty
  a_vers: assert property (p_vers) else $error("version spare bits set");
  property p_sreq_set; s_wr(UOTG_SET_OFS, 9) |=> supply_request; endproperty
  a_sreq_set: assert property (p_sreq_set) else $error("request not set");
  property p_sreq_clr; s_wr(UOTG_CLEAR_OFS, 9) |=> !supply_request; endproperty
  a_sreq_clr: assert property (p_sreq_clr) else $error("request not cleared");
  property p_irq_hold; usb_irq && !wr_en && !$past(wr_en) |=> usb_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
  property p_role; events.role_swap && en_q[5] |=> usb_irq; endproperty
  a_role: assert property (p_role) else $error("role swap irq missing");
  property p_serr; events.supply_error && en_q[3] |=> usb_irq; endproperty
  a_serr: assert property (p_serr) else $error("supply error irq missing");
  property p_pad; s_edge(supply_pad, 1) |-> ##[3:4] usb_irq; endproperty
  a_pad: assert property (p_pad) else $error("supply edge irq missing");
  property p_id; s_edge(id_pin, 0) |-> ##[3:4] usb_irq; endproperty
  a_id: assert property (p_id) else $error("id edge irq missing");
endmodule // uotg_props
bind uotg_status_flags uotg_props uotg_props_inst (.ref_clk(ref_clk), .nrst(nrst),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .events(events),
  .supply_pad(supply_pad), .id_pin(id_pin), .usb_irq(usb_irq),
  .supply_request(supply_request));

// ### tb/uotg_cable_model.sv
`timescale 1ns/10ps
module uotg_cable_model (
  input wire logic ref_clk,
  input wire logic flip_supply,
  input wire logic flip_id,
  output logic supply_pad,
  output logic id_pin
);
  // Far end moves its pads off our clock edge, never in step
  initial begin
    supply_pad = 1'b0;
    id_pin = 1'b1;
  end
  always @(posedge ref_clk) begin
    if (flip_supply) begin
      supply_pad <= #3 ~supply_pad;
    end
    if (flip_id) begin
      id_pin <= #3 ~id_pin;
    end
  end
endmodule // uotg_cable_model

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench
  import uotg_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic flip_supply = 1'b0;
  logic flip_id = 1'b0;
  uotg_events_type events = '0;
  logic [31:0] rdata;
  logic usb_irq, supply_request, clock_freeze, hwc_dis, supply_pad, id_pin;
  int n_errors = 0;
  int cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  uotg_status_flags #(.HB_ISO_EP(7'h55), .MACROCELL_16BIT(1'b1)) uotg_status_flags_inst (
    .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .events(events), .supply_pad(supply_pad),
    .id_pin(id_pin), .usb_irq(usb_irq), .supply_request(supply_request),
    .clock_freeze(clock_freeze), .supply_hw_ctrl_disable(hwc_dis));
  uotg_cable_model uotg_cable_model_inst (.ref_clk(ref_clk), .flip_supply(flip_supply),
    .flip_id(flip_id), .supply_pad(supply_pad), .id_pin(id_pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask
  // Extra edge: irq may lag an enable change by one cycle
  task automatic irq_is(input logic e);
    @(posedge ref_clk);
    #1;
    chk("usb_irq", {31'h0, e}, {31'h0, usb_irq});
  endtask
  task automatic pulse(input logic [5:0] ev);
    @(posedge ref_clk);
    events <= uotg_events_type'(ev);
    @(posedge ref_clk);
    events <= '0;
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(UOTG_STATUS_OFS, 32'h400);
    rd(UOTG_CLEAR_OFS, 32'h0);
    rd(UOTG_SET_OFS, 32'h0);
    rd(12'h900, 32'h0);
    rd(UOTG_VERSION_OFS, 32'h1);
    rd(UOTG_FEATURES_OFS, 32'h00ab70f8);
    wr(UOTG_SET_OFS, 32'h20);
    irq_is(1'b0);
    wr(UOTG_CTRL_OFS, 32'hff);
    irq_is(1'b1);
    wr(UOTG_CLEAR_OFS, 32'h20);
    irq_is(1'b0);
    for (int i = 0; i < 8; i++) begin
      wr(UOTG_SET_OFS, 32'h1 << i);
      wr(UOTG_CLEAR_OFS, 32'h0);
      rd(UOTG_STATUS_OFS, 32'h400 | (32'h1 << i));
      irq_is(1'b1);
      wr(UOTG_CLEAR_OFS, 32'h1 << i);
      rd(UOTG_STATUS_OFS, 32'h400);
      if (i >= 2) begin
        pulse(6'(1 << (i - 2)));
        rd(UOTG_STATUS_OFS, 32'h400 | (32'h1 << i));
        wr(UOTG_CLEAR_OFS, 32'hff);
      end
    end
    wr(UOTG_SET_OFS, 32'h200);
    pulse(6'h02);
    // Hardware control on: a supply fault drops the request
    rd(UOTG_STATUS_OFS, 32'h408);
    chk("supply_request", 32'h0, {31'h0, supply_request});
    chk("hw_ctrl_disable", 32'h0, {31'h0, hwc_dis});
    wr(UOTG_CLEAR_OFS, 32'hff);
    wr(UOTG_SET_OFS, 32'h200);
    wr(UOTG_CLEAR_OFS, 32'h1ff);
    wr(UOTG_CTRL_OFS, 32'h1ff);
    pulse(6'h02);
    rd(UOTG_STATUS_OFS, 32'h608);
    chk("supply_request", 32'h1, {31'h0, supply_request});
    chk("hw_ctrl_disable", 32'h1, {31'h0, hwc_dis});
    wr(UOTG_CLEAR_OFS, 32'h208);
    rd(UOTG_STATUS_OFS, 32'h400);
    // Freeze held on while the pads move
    wr(UOTG_CTRL_OFS, 32'h40ff);
    irq_is(1'b0);
    chk("clock_freeze", 32'h1, {31'h0, clock_freeze});
    @(posedge ref_clk);
    flip_supply <= 1'b1;
    @(posedge ref_clk);
    flip_supply <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(UOTG_STATUS_OFS, 32'hc02);
    wr(UOTG_CLEAR_OFS, 32'hff);
    flip_id <= 1'b1;
    @(posedge ref_clk);
    flip_id <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(UOTG_STATUS_OFS, 32'h801);
    irq_is(1'b1);
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish;
  end
endmodule // testbench
